// >>> rtl/ogs_regs.svh
// Register offsets, command codes, reset values and timing for the OLED
// pixel store and gray-scale block. Definitions only; include by bare name.
`ifndef OGS_REGS_SVH
`define OGS_REGS_SVH
// AHB-Lite byte offsets
`define OGS_REG_CMD      8'h00
`define OGS_REG_DATA     8'h04
`define OGS_REG_STATUS   8'h08
`define OGS_REG_CFG      8'h0c
`define OGS_REG_PTR      8'h10
`define OGS_REG_PROBE    8'h14
`define OGS_REG_PIXEL    8'h18
// Command codes
`define OGS_OP_COL       8'h15
`define OGS_OP_ROW       8'h75
`define OGS_OP_CONTRAST  8'h81
`define OGS_OP_REMAP     8'ha0
`define OGS_OP_START     8'ha1
`define OGS_OP_OFF       8'hae
`define OGS_OP_ON        8'haf
`define OGS_OP_CLKDIV    8'hb3
`define OGS_OP_GRAY      8'hb8
// Reset values
`define OGS_RST_CONTRAST 7'h40
`define OGS_RST_COL_END  6'h3f
`define OGS_RST_ROW_END  7'h4f
`define OGS_RST_DIV      4'h1
`define OGS_RST_GRAY     3'h1
// Remap field positions
`define OGS_RM_COL       0
`define OGS_RM_NIB       1
`define OGS_RM_VERT      2
`define OGS_RM_COM       4
// Geometry
`define OGS_ROWS         9'h050
`define OGS_ROW_LAST     9'h04f
`define OGS_DEPTH        5120
// Timing
`define OGS_CLK_KHZ      10000
`define OGS_ON_DELAY_MS  100
`define OGS_ON_CYCLES    (`OGS_ON_DELAY_MS * `OGS_CLK_KHZ)
`define OGS_ON_CNT_W     24
`endif

// >>> rtl/ogs_pkg.sv
// Types shared by the OLED pixel store and gray-scale block.
// Assumes ogs_regs.svh is on the include path.
`include "ogs_regs.svh"
package ogs_pkg;
  typedef enum logic {OGS_IDLE, OGS_ARGS} ogs_cmd_st_t;
  typedef logic [14:0][2:0] ogs_gtab_t;
  typedef struct packed {
    ogs_cmd_st_t              cst;
    logic [7:0]               op;
    logic [3:0]               argi;
    logic [3:0]               argn;
    logic [5:0]               col_s;
    logic [5:0]               col_e;
    logic [5:0]               col_p;
    logic [6:0]               row_s;
    logic [6:0]               row_e;
    logic [6:0]               row_p;
    logic [6:0]               contrast;
    logic [6:0]               remap;
    logic [6:0]               start;
    logic [3:0]               div;
    logic [3:0]               dcnt;
    logic                     tick;
    logic                     on_req;
    logic                     drv_en;
    logic [`OGS_ON_CNT_W-1:0] on_cnt;
    ogs_gtab_t                gtab;
    logic [7:0]               sr;
    logic [2:0]               sbits;
    logic                     sclk_d;
    logic                     spend;
    logic                     sdc;
    logic [7:0]               sbyte;
    logic [6:0]               p_seg;
    logic [6:0]               p_com;
    logic                     a_act;
    logic                     a_wr;
    logic [7:0]               a_addr;
    logic [31:0]              hrdata;
  } ogs_top_st_t;
  typedef struct packed {
    logic [7:0] rd;
  } ogs_store_st_t;
endpackage

// >>> rtl/ogs_store_if.sv
// Write and read port between the controller and the pixel store.
// Assumes both ends run on the same clock.
interface ogs_store_if;
  logic        wr_en;
  logic [12:0] wr_addr;
  logic [7:0]  wr_data;
  logic [12:0] rd_addr;
  logic [7:0]  rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// >>> rtl/ogs_pixel_store.sv
// Pixel store: 64 byte columns by 80 rows, two 4-bit pixels a byte.
// Assumes addresses are {row, column}; read data lags the address a cycle.
module ogs_pixel_store
  import ogs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Store port
  ogs_store_if.mem st
);
  logic [7:0]    mem_q [0:`OGS_DEPTH-1];
  ogs_store_st_t s_q;
  ogs_store_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (st.rd_addr < 13'(`OGS_DEPTH)) begin
      s_d.rd = mem_q[st.rd_addr];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // No reset on the array itself; contents are undefined until written
  always_ff @(posedge clk) begin
    if (st.wr_en && st.wr_addr < 13'(`OGS_DEPTH)) begin
      mem_q[st.wr_addr] <= st.wr_data;
    end
  end

  assign st.rd_data = s_q.rd;
endmodule

// >>> rtl/ogs_gray_pw.sv
// Gray-scale decoder: turns a 4-bit level into a drive width in ticks.
// Assumes the table is held stable by the caller; purely combinational.
module ogs_gray_pw
  import ogs_pkg::*;
(
  // Table and level
  input  wire ogs_gtab_t  gtab,
  input  wire logic [3:0] level,
  // Result
  output logic [6:0]      width,
  output logic            gray_level_zero
);
  // Entry 0 is level_one_width as is; later entries add level_width_offset
  function automatic logic [6:0] pw(ogs_gtab_t t, logic [3:0] g);
    logic [6:0] w;
    w = 7'h00;
    for (int k = 0; k < 15; k++) begin
      if (4'(k) < g) begin
        if (k == 0) begin
          w = w + {4'h0, t[k]};
        end else begin
          w = w + {4'h0, t[k]} + 7'h01;
        end
      end
    end
    return w;
  endfunction

  assign width           = pw(gtab, level);
  assign gray_level_zero = (level == 4'h0);
endmodule

// >>> rtl/ogs_top.sv
// OLED controller core: command decode, pixel store addressing, scan
// mapping probe, display tick divider and gray-scale width readout.
// Assumes a single AHB-Lite master and serial pins synchronous to clk.
//
// Contract
// - Reset: display off, normal scan, contrast 40h
// - Reset: start line is row 0
// - Reset: column address counter is 0
// - Reset clears serial shift register
// - Reset mapping: no column or row remap
// - Pixel store 64 columns by 80 rows
// - Low nibble even segment, high odd
// - Horizontal mode: column steps, then row
// - Vertical mode: row steps, then column
// - Column remap reverses; nibble remap swaps halves
// - Start line selects first scanned row
// - Row remap descends from start line, wrapping
// - Writes stay inside column/row window
// - Level zero gets no precharge or drive
// - Level one width 0 to 7 ticks
// - Later levels add offset 1 to 8
// - Reset table entries 1, widths 1..29
// - Display on enables drivers within 100 ms
// - Select high to store, low to command
// - Display tick divides clock by 1..16
//
// Added by the designer: register access over AHB-Lite and the address map.
module ogs_top
  import ogs_pkg::*;
#(
  parameter int unsigned ON_CYC = `OGS_ON_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial byte port
  input  wire logic        ser_clk,
  input  wire logic        ser_din,
  input  wire logic        ser_dc,
  input  wire logic        ser_cs_n,
  // Display timing
  output logic             display_clock_tick,
  output logic             column_drive_en,
  output logic             row_scan_en,
  output logic [6:0]       contrast_level
);
  localparam ogs_top_st_t RST = '{
    cst:      OGS_IDLE,
    contrast: `OGS_RST_CONTRAST,
    col_e:    `OGS_RST_COL_END,
    row_e:    `OGS_RST_ROW_END,
    div:      `OGS_RST_DIV,
    // Seen as high so a serial clock held high over reset is not an edge
    sclk_d:   1'b1,
    gtab:     {15{`OGS_RST_GRAY}},
    default:  '0
  };

  ogs_top_st_t q;
  ogs_top_st_t d;
  ogs_store_if st ();
  logic [3:0]  level;
  logic [6:0]  width;
  logic        zero;

  // Arguments each command takes; unknown codes take none
  function automatic logic [3:0] argc(logic [7:0] op);
    case (op)
      `OGS_OP_COL, `OGS_OP_ROW: return 4'h2;
      `OGS_OP_GRAY:             return 4'h8;
      `OGS_OP_CONTRAST, `OGS_OP_REMAP, `OGS_OP_START, `OGS_OP_CLKDIV,
      8'ha2, 8'ha8, 8'had, 8'hb0, 8'hb1, 8'hb2, 8'hb4, 8'hbc, 8'hbe:
        return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

  // Modulo 80 for sums of two row-sized terms
  function automatic logic [6:0] wrap80(logic [8:0] v);
    logic [8:0] r;
    r = v;
    if (r >= `OGS_ROWS) begin
      r = r - `OGS_ROWS;
    end
    if (r >= `OGS_ROWS) begin
      r = r - `OGS_ROWS;
    end
    return r[6:0];
  endfunction

  always_comb begin
    logic [7:0] b;
    logic       bdc;
    logic       bval;
    logic [8:0] rsum;
    logic [6:0] rrow;
    logic [5:0] pcol;
    logic [3:0] n;
    logic [3:0] gi;
    b    = 8'h00;
    bdc  = 1'b0;
    bval = 1'b0;
    rsum = 9'h000;
    rrow = 7'h00;
    pcol = 6'h00;
    n    = 4'h0;
    gi   = 4'h0;
    d    = q;
    st.wr_en   = 1'b0;
    st.wr_addr = {q.row_p, q.col_p};
    st.wr_data = 8'h00;

    // Tick every div+1 clocks
    d.tick = 1'b0;
    if (q.dcnt >= q.div) begin
      d.dcnt = 4'h0;
      d.tick = 1'b1;
    end else begin
      d.dcnt = q.dcnt + 4'h1;
    end

    // Drivers come on after the power-up delay of the panel supply
    if (q.on_req && !q.drv_en) begin
      if (q.on_cnt == `OGS_ON_CNT_W'(ON_CYC - 1)) begin
        d.drv_en = 1'b1;
      end else begin
        d.on_cnt = q.on_cnt + `OGS_ON_CNT_W'(1);
      end
    end

    // Bus write in its data phase
    if (q.a_act && q.a_wr) begin
      case (q.a_addr)
        `OGS_REG_CMD: begin
          bval = 1'b1;
          b    = hwdata[7:0];
          bdc  = 1'b0;
        end
        `OGS_REG_DATA: begin
          bval = 1'b1;
          b    = hwdata[7:0];
          bdc  = 1'b1;
        end
        `OGS_REG_PROBE: begin
          d.p_seg = hwdata[6:0];
          d.p_com = hwdata[14:8];
        end
        default: ;
      endcase
    end

    // A serial byte waits while the bus owns the byte path
    if (!bval && q.spend) begin
      bval    = 1'b1;
      b       = q.sbyte;
      bdc     = q.sdc;
      d.spend = 1'b0;
    end

    // Serial shift; deselect drops a partial byte
    d.sclk_d = ser_clk;
    if (ser_cs_n) begin
      d.sbits = 3'h0;
    end else if (ser_clk && !q.sclk_d) begin
      d.sr    = {q.sr[6:0], ser_din};
      d.sbits = q.sbits + 3'h1;
      if (q.sbits == 3'h7) begin
        d.spend = 1'b1;
        d.sbyte = {q.sr[6:0], ser_din};
        d.sdc   = ser_dc;
      end
    end

    if (bval && bdc) begin
      st.wr_en   = 1'b1;
      st.wr_data = b;
      if (!q.remap[`OGS_RM_VERT]) begin
        if (q.col_p == q.col_e) begin
          d.col_p = q.col_s;
          d.row_p = (q.row_p == q.row_e) ? q.row_s : q.row_p + 7'h01;
        end else begin
          d.col_p = q.col_p + 6'h01;
        end
      end else begin
        if (q.row_p == q.row_e) begin
          d.row_p = q.row_s;
          d.col_p = (q.col_p == q.col_e) ? q.col_s : q.col_p + 6'h01;
        end else begin
          d.row_p = q.row_p + 7'h01;
        end
      end
    end else if (bval && q.cst == OGS_IDLE) begin
      n      = argc(b);
      d.op   = b;
      d.argi = 4'h0;
      d.argn = n;
      if (n != 4'h0) begin
        d.cst = OGS_ARGS;
      end else if (b == `OGS_OP_OFF) begin
        d.on_req = 1'b0;
        d.drv_en = 1'b0;
      end else if (b == `OGS_OP_ON && !q.on_req) begin
        d.on_req = 1'b1;
        d.on_cnt = '0;
      end
    end else if (bval) begin
      unique case (q.op)
        `OGS_OP_COL: begin
          if (q.argi == 4'h0) begin
            d.col_s = b[5:0];
            d.col_p = b[5:0];
          end else begin
            d.col_e = b[5:0];
          end
        end
        `OGS_OP_ROW: begin
          if (q.argi == 4'h0) begin
            d.row_s = b[6:0];
            d.row_p = b[6:0];
          end else begin
            d.row_e = b[6:0];
          end
        end
        `OGS_OP_CONTRAST: d.contrast = b[6:0];
        `OGS_OP_REMAP:    d.remap = b[6:0];
        `OGS_OP_START:    d.start = b[6:0];
        `OGS_OP_CLKDIV:   d.div = b[3:0];
        `OGS_OP_GRAY: begin
          if (q.argi == 4'h0) begin
            d.gtab[0] = b[2:0];
          end else begin
            gi = {q.argi[2:0], 1'b0};
            d.gtab[gi - 4'h1] = b[2:0];
            d.gtab[gi]        = b[6:4];
          end
        end
        default: ;
      endcase
      d.argi = q.argi + 4'h1;
      if (q.argi + 4'h1 >= q.argn) begin
        d.cst = OGS_IDLE;
      end
    end

    // Scan probe: row scan output index to stored row
    if (q.remap[`OGS_RM_COM]) begin
      rsum = {2'b00, q.start} + `OGS_ROW_LAST - {2'b00, q.p_com};
    end else begin
      rsum = {2'b00, q.start} + {2'b00, q.p_com};
    end
    rrow = wrap80(rsum);
    pcol = q.p_seg[6:1] ^ {6{q.remap[`OGS_RM_COL]}};
    st.rd_addr = {rrow, pcol};

    // Bus address phase; read data is staged for the data phase
    d.a_act  = hsel && htrans[1] && hready;
    d.a_wr   = hwrite;
    d.a_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        `OGS_REG_STATUS:
          d.hrdata = {29'h0, q.cst == OGS_ARGS, q.on_req, q.drv_en};
        `OGS_REG_CFG:
          d.hrdata = {4'h0, q.div, 1'b0, q.start, 1'b0, q.remap,
                      1'b0, q.contrast};
        `OGS_REG_PTR:
          d.hrdata = {17'h0, q.row_p, 2'b00, q.col_p};
        `OGS_REG_PROBE:
          d.hrdata = {17'h0, q.p_com, 1'b0, q.p_seg};
        `OGS_REG_PIXEL:
          d.hrdata = {15'h0, zero, 1'b0, width, 4'h0, level};
        default:
          d.hrdata = 32'h0;
      endcase
    end
  end

  // Even segment takes the low nibble unless nibble remap swaps them
  assign level = (q.p_seg[0] ^ q.remap[`OGS_RM_NIB]) ?
                 st.rd_data[7:4] : st.rd_data[3:0];

  // Reset loads display off, 40h contrast, origin pointers, table of ones
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end
  // Start line, column counter, shift register and table all reset above

  ogs_pixel_store u_store (
    .clk  (clk),
    .rstn (rstn),
    .st   (st.mem)
  );

  ogs_gray_pw u_gray (
    .gtab            (q.gtab),
    .level           (level),
    .width           (width),
    .gray_level_zero (zero)
  );

  // Zero wait states, always OKAY
  assign hrdata             = q.hrdata;
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign display_clock_tick = q.tick;
  assign column_drive_en    = q.drv_en;
  assign row_scan_en        = q.drv_en;
  assign contrast_level     = q.contrast;
endmodule

// >>> bench/ogs_host_ser.sv
// Host model on the serial byte port: shifts bytes in MSB first.
// Assumes the caller starts each send just after a rising clk edge.
module ogs_host_ser (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      ser_clk,
  output logic      ser_din,
  output logic      ser_dc,
  output logic      ser_cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_clk  = 1'b0;
    ser_din  = 1'b0;
    ser_dc   = 1'b0;
    ser_cs_n = 1'b1;
  end
  // Fewer than 8 bits leaves the select low, as a host cut off mid-byte
  task automatic send(input logic [7:0] b, input logic dc, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      ser_cs_n <= 1'b0;
      ser_dc   <= dc;
      ser_din  <= b[7-i];
      ser_clk  <= 1'b0;
      repeat (2) @(posedge clk);
      ser_clk <= 1'b1;
      @(posedge clk);
    end
    if (nb == 8) begin
      repeat (2) @(posedge clk);
      // Clock stands low between frames; data flips so it is never stale
      ser_clk  <= 1'b0;
      ser_cs_n <= 1'b1;
      ser_din  <= ~ser_din;
    end
  endtask
endmodule

// >>> bench/ogs_top_sva.sv
// Checker for the controller core, watching only its top ports.
// Assumes a zero-wait AHB-Lite slave; bound from the bench top.
module ogs_top_sva #(
  parameter int unsigned ON_CYC = 20
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Display timing
  input wire logic        display_clock_tick,
  input wire logic        column_drive_en,
  input wire logic        row_scan_en,
  input wire logic [6:0]  contrast_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        aw_q;
  logic        c81_q;
  logic        pend_q;
  logic [6:0]  arg_q;
  logic [4:0]  gap_q;
  logic [31:0] wait_q;
  logic [7:0]  cmd_b;
  // Only bus commands are tracked; serial commands are judged by the bench
  assign cmd_b = hwdata[7:0];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_q   <= 1'b0;
      c81_q  <= 1'b0;
      pend_q <= 1'b0;
      arg_q  <= 7'h0;
      gap_q  <= 5'h0;
      wait_q <= 32'h0;
    end else begin
      aw_q <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
      if (aw_q) c81_q <= cmd_b == 8'h81;
      if (aw_q && c81_q) arg_q <= cmd_b[6:0];
      if (aw_q && cmd_b == 8'haf) begin
        pend_q <= 1'b1;
      end else if (column_drive_en || (aw_q && cmd_b == 8'hae)) begin
        pend_q <= 1'b0;
      end
      wait_q <= (pend_q && !column_drive_en) ? wait_q + 32'h1 : 32'h0;
      // Saturates so a stuck divider cannot wrap back under the bound
      gap_q <= display_clock_tick ? 5'h0 : gap_q + {4'h0, gap_q != 5'h1f};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_drive_pair: assert property (
    column_drive_en == row_scan_en) else $error("drivers disagree");
  a_on_bound: assert property (wait_q <= ON_CYC + 4)
    else $error("display on too late");
  a_on_cause: assert property (
    $rose(column_drive_en) |-> $past(pend_q))
    else $error("drivers on without request");
  a_reset_vals: assert property ($rose(rstn) |->
    contrast_level == 7'h40 && !column_drive_en && !row_scan_en)
    else $error("reset state wrong");
  a_tick_first: assert property (
    $rose(rstn) |-> !display_clock_tick) else $error("tick in reset");
  a_tick_gap: assert property (gap_q < 5'd16)
    else $error("tick gap above sixteen");
  a_contrast_arg: assert property ((aw_q && c81_q) |->
    ##[1:2] contrast_level == arg_q) else $error("contrast not taken");
  a_off_cmd: assert property ((aw_q && cmd_b == 8'hae) |->
    ##[1:2] !column_drive_en) else $error("display off ignored");
  c_on: cover property ($rose(column_drive_en));
  c_arg: cover property (aw_q && c81_q);
  c_gap: cover property (gap_q == 5'd15);
endmodule

// >>> bench/tb_oled_gram_map_and_gray_scale.sv
// Bench for the controller core: bus tasks, pixel probes and verdict.
// Assumes the serial host model and the checker file are compiled first.
module tb_oled_gram_map_and_gray_scale;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned ON_CYC = 20;
  logic        clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic        ser_clk, ser_din, ser_dc, ser_cs_n, tick, cdrv, rscan;
  logic [1:0]  htrans;
  logic [2:0]  hsize, l1, oc;
  logic [6:0]  contrast;
  logic [7:0]  dv [3] = '{8'h00, 8'h03, 8'h0f};
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          fails, check_count, n, c;
  assign hready = hreadyout;
  ogs_top #(.ON_CYC(ON_CYC)) i_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ser_clk(ser_clk), .ser_din(ser_din), .ser_dc(ser_dc),
    .ser_cs_n(ser_cs_n), .display_clock_tick(tick),
    .column_drive_en(cdrv), .row_scan_en(rscan), .contrast_level(contrast));
  ogs_host_ser i_host (.clk(clk), .ser_clk(ser_clk), .ser_din(ser_din),
    .ser_dc(ser_dc), .ser_cs_n(ser_cs_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 99);
    if (hready !== 1'b1) fails++;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rdv = hrdata;
  endtask
  task automatic cmd(input logic [7:0] b);
    bus(1'b1, 8'h00, {24'h0, b});
  endtask
  task automatic dat(input logic [7:0] b);
    bus(1'b1, 8'h04, {24'h0, b});
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task automatic win(input logic [7:0] cs, ce, rs, re);
    cmd(8'h15);
    cmd(cs);
    cmd(ce);
    cmd(8'h75);
    cmd(rs);
    cmd(re);
  endtask
  // Width expected from the table held in l1 and oc
  task automatic pix(input logic [6:0] s, r, input logic [3:0] lv);
    logic [6:0] w;
    w = (lv == 4'h0) ? 7'h0 : 7'(l1) + 7'(lv - 4'h1) * (7'(oc) + 7'h1);
    bus(1'b1, 8'h14, {17'h0, r, 1'b0, s});
    repeat (3) @(posedge clk);
    rchk("pixel", 8'h18, {15'h0, lv == 4'h0, 1'b0, w, 4'h0, lv});
  endtask
  task automatic ticks(input int cyc, input logic [31:0] e);
    c = 0;
    // Let a new divide ratio govern every counted pulse
    @(posedge clk);
    repeat (cyc) begin
      @(negedge clk);
      if (tick === 1'b1) c++;
    end
    @(posedge clk);
    chk("ticks", e, c);
  endtask
  task automatic conclude;
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The longest stretch is the window fill, about ten thousand cycles
  initial begin
    #6000000;
    fails++;
    conclude();
  end
  initial begin
    {fails, check_count, rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    l1 = 3'h1;
    oc = 3'h1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk("cfg", 8'h0c, 32'h0100_0040);
    rchk("status", 8'h08, 32'h0);
    chk("resp", 32'h0, {31'h0, hresp});
    rchk("ptr", 8'h10, 32'h0);
    rchk("spare", 8'h1c, 32'h0);
    chk("contrast", 32'h40, {25'h0, contrast});
    ticks(48, 24);
    for (n = 0; n < 3; n++) begin
      cmd(8'hb3);
      cmd(dv[n]);
      ticks(48, 48 / (dv[n] + 1));
    end
    cmd(8'hb3);
    cmd(8'h01);
    for (n = 0; n < 64; n++) dat({n[2:0], 1'b1, n[2:0], 1'b0});
    rchk("ptr", 8'h10, 32'h100);
    for (n = 0; n < 16; n++) pix(n[6:0], 7'h0, n[3:0]);
    win(8'h01, 8'h3e, 8'h01, 8'h4e);
    rchk("ptr", 8'h10, 32'h101);
    for (n = 0; n < 62; n++) dat(8'hff);
    rchk("ptr", 8'h10, 32'h201);
    for (n = 62; n < 4836; n++) dat(8'hff);
    rchk("ptr", 8'h10, 32'h101);
    win(8'h00, 8'h3f, 8'h00, 8'h4f);
    cmd(8'ha0);
    cmd(8'h04);
    for (n = 0; n < 80; n++) dat(n[7:0] + 8'h1);
    rchk("ptr", 8'h10, 32'h1);
    dat(8'h00);
    rchk("ptr", 8'h10, 32'h101);
    win(8'h00, 8'h3f, 8'h00, 8'h4f);
    cmd(8'ha0);
    cmd(8'h03);
    dat(8'h9a);
    pix(7'd126, 7'd0, 4'h9);
    pix(7'd127, 7'd0, 4'ha);
    pix(7'd0, 7'd0, 4'hf);
    cmd(8'ha0);
    cmd(8'h00);
    cmd(8'ha1);
    cmd(8'h01);
    pix(7'd0, 7'd0, 4'h2);
    cmd(8'ha0);
    cmd(8'h10);
    cmd(8'ha1);
    cmd(8'h10);
    rchk("cfg", 8'h0c, 32'h0110_1040);
    pix(7'd0, 7'd15, 4'ha);
    pix(7'd0, 7'd14, 4'h2);
    for (n = 0; n < 2; n++) begin
      l1 = (n == 0) ? 3'h7 : 3'h0;
      oc = l1;
      cmd(8'hb8);
      cmd({5'h0, l1});
      repeat (7) cmd({1'b0, oc, 1'b0, oc});
      pix(7'd0, 7'd14, 4'h2);
      pix(7'd1, 7'd14, 4'h0);
      pix(7'd0, 7'd15, 4'ha);
    end
    cmd(8'h81);
    rchk("status", 8'h08, 32'h4);
    cmd(8'h2a);
    repeat (2) @(posedge clk);
    chk("contrast", 32'h2a, {25'h0, contrast});
    i_host.send(8'h81, 1'b0, 8);
    i_host.send(8'h55, 1'b0, 8);
    i_host.send(8'h33, 1'b1, 8);
    repeat (3) @(posedge clk);
    chk("contrast", 32'h55, {25'h0, contrast});
    rchk("ptr", 8'h10, 32'h2);
    cmd(8'haf);
    rchk("status", 8'h08, 32'h2);
    for (n = 0; n < 40 && cdrv !== 1'b1; n++) @(posedge clk);
    rchk("status", 8'h08, 32'h3);
    chk("drive", 32'h3, {30'h0, cdrv, rscan});
    cmd(8'hae);
    repeat (2) @(posedge clk);
    chk("drive", 32'h0, {30'h0, cdrv, rscan});
    // A byte cut off by reset must not shift the next one
    i_host.send(8'hf0, 1'b0, 4);
    rstn <= 1'b0;
    repeat (30) @(posedge clk);
    rstn <= 1'b1;
    i_host.send(8'h81, 1'b0, 8);
    i_host.send(8'h3c, 1'b0, 8);
    repeat (3) @(posedge clk);
    chk("contrast", 32'h3c, {25'h0, contrast});
    conclude();
  end
endmodule
bind ogs_top ogs_top_sva #(.ON_CYC(ON_CYC)) i_sva (.clk(clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .display_clock_tick(display_clock_tick), .column_drive_en(column_drive_en),
  .row_scan_en(row_scan_en), .contrast_level(contrast_level));
